// >>> rtl/mode_ctrl_pkg.sv
// Package with mode encodings, command codes, error codes and timing counts.
package mode_ctrl_pkg;

   // ----------------------------------------
   // Working modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_INIT_COPY = 3'b000,
      ST_INIT_CFG  = 3'b001,
      ST_NORMAL    = 3'b010,
      ST_CMD_WAIT  = 3'b011,
      ST_CMD_EXEC  = 3'b100,
      ST_DIAG      = 3'b101
   } mode_type;

   // ----------------------------------------
   // Command codes and error codes
   // ----------------------------------------
   localparam logic [15:0] CMD_ENTER_COMMAND = 16'h72D1;
   localparam logic [15:0] CMD_NVM_UNLOCK = 16'h00A0;
   localparam logic [15:0] CMD_REINIT = 16'h00A1;
   localparam logic [15:0] CMD_MEASURE = 16'h00A2;
   localparam logic [15:0] ERR_WATCHDOG = 16'hC008;
   localparam logic [15:0] ERR_RAM_PARITY = 16'hC001;
   localparam logic [15:0] ERR_COUNTED = 16'hC010;
   localparam logic [15:0] ERR_NVM = 16'hC004;

   // ----------------------------------------
   // Counts and widths
   // ----------------------------------------
   localparam int WATCHDOG_CLOCKS = 69632;
   localparam int FAIL_LIMIT = 2;
   localparam int DATA_WIDTH = 16;
   localparam logic [11:0] DIAG_DAC_LEVEL = 12'h000;

endpackage

// >>> rtl/temp_check.sv
// Temperature raw value range check.
`timescale 1ns/1ps
module temp_check (
   // Raw value and resolution select
   input wire logic [15:0] raw,
   input wire logic [1:0] res_sel,
   // Result
   output logic fail
);
   // -----------------------------
   // Range check
   // -----------------------------
   // Resolution codes: 0 = 13, 1 = 14, 2 = 15 (reduced to 13), 3 = 16 (reduced to 14).
   wire [15:0] reduced = (res_sel == 2'd2) ? {2'b00, raw[15:2]} :
                         (res_sel == 2'd3) ? {2'b00, raw[15:2]} : raw;
   wire [15:0] max_val = res_sel[0] ? 16'h3FFF : 16'h1FFF;
   assign fail = (reduced == 16'h0000) || (reduced >= max_val);
endmodule

// >>> rtl/working_mode_control.sv
// Working mode controller of the sensor signal conditioner.
`timescale 1ns/1ps
// What this block does
// - Power-on copies checked memory, then configures.
// - Normal mode updates result every cycle.
// - Serial result read never disturbs conditioning.
// - Only entry command enters command mode.
// - Other commands in normal mode are discarded.
// - Command mode executes all; interface busy.
// - After command wait, or loop measurement.
// - Memory writes locked until unlock command.
// - Entry accepted two-wire always, one-wire optional.
// - Diagnostic drives low range, loads error code.
// - Diagnostic enables both serial interfaces.
// - RAM parity mismatch forces diagnostic mode.
// - Two failures enter, countdown leaves diagnostic.
// - Temperature zero or full scale fails.
// - Temperature failures go through the counter.
// - Reinit command recopies memory like power-on.
// - Conversion runs continuously, started by controller.
// - Datapath operands are sixteen bits wide.
// - Temperature and sensor checks individually enableable.
// - Start routine watchdog loads code, diagnoses.
// - Watchdog code replaces earlier error codes.
// - RAM parity loads its own error code.
module working_mode_control #(
   parameter int WATCHDOG_LIMIT = mode_ctrl_pkg::WATCHDOG_CLOCKS,
   parameter int FAIL_MAX = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Memory copy engine
   input wire logic copy_done,
   input wire logic copy_error,
   output logic copy_start,
   output logic config_apply,
   // RAM read parity
   input wire logic ram_rd_valid,
   input wire logic [15:0] ram_rd_data,
   input wire logic ram_rd_parity,
   // Commands from the serial interfaces
   input wire logic cmd_valid,
   input wire logic cmd_from_one_wire,
   input wire logic [15:0] cmd_code,
   input wire logic cmd_done,
   input wire logic one_wire_entry_allowed,
   // Measurement cycle
   input wire logic cycle_end,
   input wire logic [15:0] cond_result,
   input wire logic [15:0] temp_raw,
   input wire logic temp_valid,
   input wire logic [1:0] adc_res,
   // Check enables and other failures
   input wire logic chk_temp_en,
   input wire logic chk_sensor_en,
   input wire logic sensor_fail,
   input wire logic hard_fail,
   // Mode and status outputs
   output logic [2:0] mode,
   output logic conv_run,
   output logic cmd_busy,
   output logic cmd_ack,
   output logic nvm_write_en,
   output logic two_wire_en,
   output logic one_wire_en,
   output logic [15:0] serial_out,
   output logic [11:0] dac_value,
   output logic diag_low
);

   // ------------------------------------------------
   // State
   // ------------------------------------------------
   mode_ctrl_pkg::mode_type state_q, state_d;
   logic [16:0] wdog_q;
   logic [3:0] fail_q;
   logic temp_diag_q;
   logic unlock_q;
   logic loop_q;
   logic [15:0] err_q;
   logic [15:0] result_q;
   logic copy_pend_q;

   function automatic logic odd_parity_ok(input logic [15:0] d, input logic p);
      odd_parity_ok = ((^d) ^ p) == 1'b0;
   endfunction

   // ------------------------------------------------
   // Decoding
   // ------------------------------------------------
   wire is_entry = cmd_code == mode_ctrl_pkg::CMD_ENTER_COMMAND;
   wire entry_ok = cmd_valid && is_entry && (!cmd_from_one_wire || one_wire_entry_allowed);
   wire in_init = (state_q == mode_ctrl_pkg::ST_INIT_COPY) ||
                  (state_q == mode_ctrl_pkg::ST_INIT_CFG);
   wire parity_err = ram_rd_valid && !odd_parity_ok(ram_rd_data, ram_rd_parity);
   wire wdog_err = in_init && (wdog_q == 17'(WATCHDOG_LIMIT - 1));
   wire init_err = (state_q == mode_ctrl_pkg::ST_INIT_COPY) && copy_done && copy_error;
   wire hard_err = parity_err || wdog_err || init_err || hard_fail;
   logic temp_fail;
   temp_check u_temp (
      .raw(temp_raw),
      .res_sel(adc_res),
      .fail(temp_fail)
   );
   // Counted failures are sampled once per measurement cycle.
   wire counted_fail = (chk_temp_en && temp_valid && temp_fail) ||
                       (chk_sensor_en && sensor_fail);
   wire measuring = (state_q == mode_ctrl_pkg::ST_NORMAL) || loop_q;
   wire cmd_accept = cmd_valid && (state_q == mode_ctrl_pkg::ST_CMD_WAIT);

   // ------------------------------------------------
   // Next mode
   // ------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         mode_ctrl_pkg::ST_INIT_COPY: begin
            if (copy_done) begin
               state_d = mode_ctrl_pkg::ST_INIT_CFG;
            end
         end
         mode_ctrl_pkg::ST_INIT_CFG: state_d = mode_ctrl_pkg::ST_NORMAL;
         mode_ctrl_pkg::ST_NORMAL: begin
            if (entry_ok) begin
               state_d = mode_ctrl_pkg::ST_CMD_WAIT;
            end
         end
         mode_ctrl_pkg::ST_CMD_WAIT: begin
            if (cmd_accept && cmd_code == mode_ctrl_pkg::CMD_REINIT) begin
               state_d = mode_ctrl_pkg::ST_INIT_COPY;
            end else if (cmd_accept && !is_entry) begin
               state_d = mode_ctrl_pkg::ST_CMD_EXEC;
            end
         end
         mode_ctrl_pkg::ST_CMD_EXEC: begin
            if (cmd_done) begin
               state_d = mode_ctrl_pkg::ST_CMD_WAIT;
            end
         end
         mode_ctrl_pkg::ST_DIAG: begin
            if (entry_ok) begin
               state_d = mode_ctrl_pkg::ST_CMD_WAIT;
            end else if (temp_diag_q && fail_q == 4'd0 && !hard_err) begin
               state_d = mode_ctrl_pkg::ST_NORMAL;
            end
         end
         default: state_d = mode_ctrl_pkg::ST_INIT_COPY;
      endcase
      if (hard_err) begin
         state_d = mode_ctrl_pkg::ST_DIAG;
      end else if (measuring && cycle_end && counted_fail &&
                   fail_q >= 4'(mode_ctrl_pkg::FAIL_LIMIT - 1)) begin
         state_d = mode_ctrl_pkg::ST_DIAG;
      end
   end

   // ------------------------------------------------
   // Registers
   // ------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= mode_ctrl_pkg::ST_INIT_COPY;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !in_init) begin
         wdog_q <= 17'h0_0000;
      end else if (!wdog_err) begin
         wdog_q <= wdog_q + 17'h0_0001;
      end
   end

   // Failure counter: up on a failing cycle, down on a clean one.
   always_ff @(posedge clk) begin
      if (rst) begin
         fail_q <= 4'h0;
      end else if ((measuring || temp_diag_q) && cycle_end) begin
         if (counted_fail && fail_q < 4'(FAIL_MAX)) begin
            fail_q <= fail_q + 4'h1;
         end else if (!counted_fail && fail_q != 4'h0) begin
            fail_q <= fail_q - 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || hard_err) begin
         temp_diag_q <= 1'b0;
      end else if (state_d == mode_ctrl_pkg::ST_DIAG && state_q != mode_ctrl_pkg::ST_DIAG) begin
         temp_diag_q <= 1'b1;
      end else if (state_q != mode_ctrl_pkg::ST_DIAG) begin
         temp_diag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_q != mode_ctrl_pkg::ST_CMD_WAIT && state_q != mode_ctrl_pkg::ST_CMD_EXEC) begin
         unlock_q <= 1'b0;
      end else if (cmd_accept && cmd_code == mode_ctrl_pkg::CMD_NVM_UNLOCK) begin
         unlock_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_q != mode_ctrl_pkg::ST_CMD_EXEC && state_q != mode_ctrl_pkg::ST_CMD_WAIT) begin
         loop_q <= 1'b0;
      end else if (cmd_accept) begin
         loop_q <= cmd_code == mode_ctrl_pkg::CMD_MEASURE;
      end
   end

   // Error code register: codes are ORed, the watchdog code replaces others.
   always_ff @(posedge clk) begin
      if (rst) begin
         err_q <= 16'h0000;
      end else if (wdog_err) begin
         err_q <= mode_ctrl_pkg::ERR_WATCHDOG;
      end else if (parity_err) begin
         err_q <= err_q | mode_ctrl_pkg::ERR_RAM_PARITY;
      end else if (init_err) begin
         err_q <= err_q | mode_ctrl_pkg::ERR_NVM;
      end else if (state_d == mode_ctrl_pkg::ST_DIAG && state_q != mode_ctrl_pkg::ST_DIAG) begin
         err_q <= err_q | mode_ctrl_pkg::ERR_COUNTED;
      end
   end

   // Result is latched once per cycle; reads never stall the controller.
   always_ff @(posedge clk) begin
      if (rst) begin
         result_q <= 16'h0000;
      end else if (measuring && cycle_end) begin
         result_q <= cond_result;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         copy_pend_q <= 1'b1;
      end else begin
         copy_pend_q <= state_d == mode_ctrl_pkg::ST_INIT_COPY && state_q != mode_ctrl_pkg::ST_INIT_COPY;
      end
   end

   // ------------------------------------------------
   // Outputs
   // ------------------------------------------------
   wire in_diag = state_q == mode_ctrl_pkg::ST_DIAG;
   assign mode = state_q;
   assign copy_start = copy_pend_q;
   assign config_apply = state_q == mode_ctrl_pkg::ST_INIT_CFG;
   assign conv_run = measuring;
   assign cmd_busy = state_q == mode_ctrl_pkg::ST_CMD_EXEC;
   assign cmd_ack = cmd_accept || (entry_ok && (state_q == mode_ctrl_pkg::ST_NORMAL || in_diag));
   assign nvm_write_en = unlock_q;
   assign two_wire_en = !cmd_busy;
   assign one_wire_en = in_diag || !cmd_busy;
   assign serial_out = in_diag ? err_q : result_q;
   assign dac_value = in_diag ? mode_ctrl_pkg::DIAG_DAC_LEVEL : result_q[15:4];
   assign diag_low = in_diag;

   // ------------------------------------------------
   // Checks
   // ------------------------------------------------
   sequence entry_seen_s;
      state_q == mode_ctrl_pkg::ST_NORMAL && entry_ok && !hard_err;
   endsequence

   entry_to_cmd_a: assert property (@(posedge clk) disable iff (rst)
      entry_seen_s |=> state_q == mode_ctrl_pkg::ST_CMD_WAIT)
      else $error("entry command did not enter command mode");
   other_cmd_ignored_a: assert property (@(posedge clk) disable iff (rst)
      state_q == mode_ctrl_pkg::ST_NORMAL && cmd_valid && !is_entry && !hard_err && !counted_fail
      |=> state_q == mode_ctrl_pkg::ST_NORMAL)
      else $error("non-entry command left normal mode");
   parity_diag_a: assert property (@(posedge clk) disable iff (rst)
      parity_err |=> in_diag && err_q[0])
      else $error("parity error did not force diagnostics");
   wdog_code_a: assert property (@(posedge clk) disable iff (rst)
      wdog_err |=> err_q == mode_ctrl_pkg::ERR_WATCHDOG)
      else $error("watchdog code not loaded");
   diag_output_a: assert property (@(posedge clk) disable iff (rst)
      in_diag |-> dac_value == mode_ctrl_pkg::DIAG_DAC_LEVEL && serial_out == err_q)
      else $error("diagnostic outputs wrong");
   busy_blocks_a: assert property (@(posedge clk) disable iff (rst)
      cmd_busy |-> !cmd_accept && !two_wire_en)
      else $error("command accepted while busy");
   unlock_gate_a: assert property (@(posedge clk) disable iff (rst)
      $rose(nvm_write_en) |-> $past(cmd_accept) && $past(cmd_code) == mode_ctrl_pkg::CMD_NVM_UNLOCK)
      else $error("write enabled without unlock");
   two_fail_a: assert property (@(posedge clk) disable iff (rst)
      state_q == mode_ctrl_pkg::ST_NORMAL && fail_q == 4'd0 && cycle_end && counted_fail && !hard_err
      |=> state_q == mode_ctrl_pkg::ST_NORMAL)
      else $error("single failure entered diagnostics");
   init_seq_a: assert property (@(posedge clk) disable iff (rst)
      state_q == mode_ctrl_pkg::ST_INIT_COPY && copy_done && !hard_err
      |=> config_apply ##1 state_q == mode_ctrl_pkg::ST_NORMAL || in_diag)
      else $error("init sequence broken");

   sequence reinit_taken_s;
      cmd_accept && cmd_code == mode_ctrl_pkg::CMD_REINIT && !hard_err &&
      !(cycle_end && counted_fail);
   endsequence
   sequence copy_restart_s;
      state_q == mode_ctrl_pkg::ST_INIT_COPY && copy_start;
   endsequence
   sequence second_fail_s;
      measuring && cycle_end && counted_fail && fail_q == 4'd1 && !hard_err;
   endsequence

   reinit_copy_a: assert property (@(posedge clk) disable iff (rst)
      reinit_taken_s |=> copy_restart_s)
      else $error("reinit command did not restart the copy");
   entry_stops_a: assert property (@(posedge clk) disable iff (rst)
      entry_seen_s |=> !conv_run)
      else $error("measurement kept running after entry");
   busy_release_a: assert property (@(posedge clk) disable iff (rst)
      cmd_busy && cmd_done |=> state_q == mode_ctrl_pkg::ST_CMD_WAIT || in_diag)
      else $error("command end did not return to waiting");
   diag_ifaces_a: assert property (@(posedge clk) disable iff (rst)
      in_diag |-> one_wire_en && two_wire_en)
      else $error("serial interfaces closed in diagnostics");
   result_latch_a: assert property (@(posedge clk) disable iff (rst)
      measuring && cycle_end |=> result_q == $past(cond_result))
      else $error("result not refreshed at cycle end");
   result_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(measuring && cycle_end) |=> $stable(result_q))
      else $error("result changed between cycle ends");
   second_fail_a: assert property (@(posedge clk) disable iff (rst)
      second_fail_s |=> in_diag)
      else $error("second failure did not enter diagnostics");
   diag_hold_a: assert property (@(posedge clk) disable iff (rst)
      in_diag && fail_q != 4'd0 |=> state_q != mode_ctrl_pkg::ST_NORMAL)
      else $error("diagnostics left with failures counted");
   nvm_locked_a: assert property (@(posedge clk) disable iff (rst)
      state_q == mode_ctrl_pkg::ST_NORMAL |-> !nvm_write_en)
      else $error("memory writes open in normal mode");

endmodule

// >>> verif/mcu_model.sv
// Calibration master model that issues serial commands to the block.
`timescale 1ns/1ps
module mcu_model (
   // Clock and answer
   input wire logic clk,
   input wire logic cmd_ack,
   // Command towards the block
   output logic cmd_valid,
   output logic cmd_from_one_wire,
   output logic [15:0] cmd_code
);
   initial begin
      cmd_valid = 1'b0;
      cmd_from_one_wire = 1'b0;
      cmd_code = 16'h0000;
   end
   // Presents one command for one cycle and reports the acknowledge.
   task automatic send(input logic [15:0] code, input logic ow, output logic ack);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code = code;
      // On the one-wire link the master overdrives the held-low pin.
      cmd_from_one_wire = ow;
      #1 ack = cmd_ack;
      @(negedge clk);
      cmd_valid = 1'b0;
      // A released bus does not keep showing the last code.
      cmd_code = ~code;
   endtask
endmodule

// >>> verif/working_mode_control_tb_top.sv
// Self-checking testbench of the working mode controller.
`timescale 1ns/1ps
module working_mode_control_tb_top;
   localparam logic [2:0] CFG = mode_ctrl_pkg::ST_INIT_CFG;
   localparam logic [2:0] NRM = mode_ctrl_pkg::ST_NORMAL;
   localparam logic [2:0] WAI = mode_ctrl_pkg::ST_CMD_WAIT;
   localparam logic [2:0] EXE = mode_ctrl_pkg::ST_CMD_EXEC;
   localparam logic [2:0] DIA = mode_ctrl_pkg::ST_DIAG;
   logic clk, rst, copy_done, copy_error, ram_rd_valid, ram_rd_parity, cmd_done, ow_ok;
   logic cycle_end, temp_valid, chk_temp_en, chk_sensor_en, sensor_fail, hard_fail;
   logic [15:0] ram_rd_data, cond_result, temp_raw;
   logic [1:0] adc_res;
   logic cmd_valid, cmd_from_one_wire, copy_start, config_apply, conv_run, cmd_busy, cmd_ack;
   logic nvm_write_en, two_wire_en, one_wire_en, diag_low, ack;
   logic [15:0] cmd_code, serial_out;
   logic [11:0] dac_value;
   logic [2:0] mode;
   int miscompares, tests_run, starts;

   mcu_model i_mcu_model (.clk(clk), .cmd_ack(cmd_ack), .cmd_valid(cmd_valid),
      .cmd_from_one_wire(cmd_from_one_wire), .cmd_code(cmd_code));
   working_mode_control #(.WATCHDOG_LIMIT(64), .FAIL_MAX(3)) i_working_mode_control (
      .clk(clk), .rst(rst), .copy_done(copy_done), .copy_error(copy_error),
      .copy_start(copy_start), .config_apply(config_apply), .ram_rd_valid(ram_rd_valid),
      .ram_rd_data(ram_rd_data), .ram_rd_parity(ram_rd_parity), .cmd_valid(cmd_valid),
      .cmd_from_one_wire(cmd_from_one_wire), .cmd_code(cmd_code), .cmd_done(cmd_done),
      .one_wire_entry_allowed(ow_ok), .cycle_end(cycle_end), .cond_result(cond_result),
      .temp_raw(temp_raw), .temp_valid(temp_valid), .adc_res(adc_res),
      .chk_temp_en(chk_temp_en), .chk_sensor_en(chk_sensor_en), .sensor_fail(sensor_fail),
      .hard_fail(hard_fail), .mode(mode), .conv_run(conv_run), .cmd_busy(cmd_busy),
      .cmd_ack(cmd_ack), .nvm_write_en(nvm_write_en), .two_wire_en(two_wire_en),
      .one_wire_en(one_wire_en), .serial_out(serial_out), .dac_value(dac_value),
      .diag_low(diag_low));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (copy_start === 1'b1) starts++;
   end

   // ----------------------------------------
   // Compare and helper tasks
   // ----------------------------------------
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_m(input logic [2:0] got, input logic [2:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_mode(input logic [2:0] m, input int n);
      for (int i = 0; i < n && mode !== m; i++) cyc(1);
   endtask
   task automatic boot(input int n);
      @(negedge clk);
      rst = 1'b1;
      cyc(n);
      rst = 1'b0;
      cyc(2);
      copy_done = 1'b1;
      wait_mode(CFG, 10);
      chk_m(mode, CFG);
      chk_b(config_apply, 1'b1);
      copy_done = 1'b0;
      wait_mode(NRM, 5);
      chk_m(mode, NRM);
   endtask
   task automatic pulse_cycle();
      cycle_end = 1'b1;
      cyc(1);
      cycle_end = 1'b0;
      cyc(1);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_normal();
      cond_result = 16'hA5C3;
      pulse_cycle();
      chk_w(serial_out, 16'hA5C3);
      chk_w({4'h0, dac_value}, 16'h0A5C);
      chk_b(conv_run, 1'b1);
   endtask
   task automatic t_entry();
      i_mcu_model.send(mode_ctrl_pkg::CMD_NVM_UNLOCK, 1'b0, ack);
      chk_b(ack, 1'b0);
      chk_m(mode, NRM);
      ow_ok = 1'b0;
      i_mcu_model.send(mode_ctrl_pkg::CMD_ENTER_COMMAND, 1'b1, ack);
      chk_b(ack, 1'b0);
      chk_m(mode, NRM);
      i_mcu_model.send(mode_ctrl_pkg::CMD_ENTER_COMMAND, 1'b0, ack);
      chk_b(ack, 1'b1);
      chk_m(mode, WAI);
      chk_b(conv_run, 1'b0);
   endtask
   task automatic t_commands();
      int s0;
      chk_b(nvm_write_en, 1'b0);
      i_mcu_model.send(mode_ctrl_pkg::CMD_NVM_UNLOCK, 1'b0, ack);
      chk_m(mode, EXE);
      chk_b(cmd_busy, 1'b1);
      chk_b(two_wire_en, 1'b0);
      chk_b(one_wire_en, 1'b0);
      i_mcu_model.send(mode_ctrl_pkg::CMD_REINIT, 1'b0, ack);
      chk_b(ack, 1'b0);
      cmd_done = 1'b1;
      cyc(1);
      cmd_done = 1'b0;
      chk_m(mode, WAI);
      chk_b(nvm_write_en, 1'b1);
      s0 = starts;
      i_mcu_model.send(mode_ctrl_pkg::CMD_REINIT, 1'b0, ack);
      cyc(3);
      chk_b(starts != s0, 1'b1);
      copy_done = 1'b1;
      wait_mode(NRM, 10);
      copy_done = 1'b0;
      chk_m(mode, NRM);
      ow_ok = 1'b1;
      i_mcu_model.send(mode_ctrl_pkg::CMD_ENTER_COMMAND, 1'b1, ack);
      chk_b(ack, 1'b1);
      i_mcu_model.send(mode_ctrl_pkg::CMD_MEASURE, 1'b0, ack);
      chk_b(conv_run, 1'b1);
      hard_fail = 1'b1;
      cyc(1);
      hard_fail = 1'b0;
      cyc(1);
      chk_m(mode, DIA);
   endtask
   task automatic t_counted();
      sensor_fail = 1'b1;
      repeat (3) pulse_cycle();
      chk_m(mode, NRM);
      chk_sensor_en = 1'b1;
      pulse_cycle();
      chk_m(mode, NRM);
      pulse_cycle();
      chk_m(mode, DIA);
      sensor_fail = 1'b0;
      chk_sensor_en = 1'b0;
      repeat (2) pulse_cycle();
      chk_m(mode, NRM);
      chk_temp_en = 1'b1;
      temp_valid = 1'b1;
      temp_raw = 16'h1000;
      repeat (2) pulse_cycle();
      chk_m(mode, NRM);
      temp_raw = 16'h0000;
      pulse_cycle();
      chk_m(mode, NRM);
      adc_res = 2'h3;
      temp_raw = 16'hFFFC;
      pulse_cycle();
      chk_m(mode, DIA);
      chk_w(serial_out, mode_ctrl_pkg::ERR_COUNTED);
      chk_w({4'h0, dac_value}, {4'h0, mode_ctrl_pkg::DIAG_DAC_LEVEL});
      chk_b(diag_low, 1'b1);
      chk_b(two_wire_en & one_wire_en, 1'b1);
      adc_res = 2'h0;
      temp_raw = 16'h1000;
      for (int i = 0; i < 6 && mode !== NRM; i++) pulse_cycle();
      chk_m(mode, NRM);
   endtask
   task automatic t_parity();
      ram_rd_data = 16'h0001;
      ram_rd_parity = 1'b1;
      ram_rd_valid = 1'b1;
      cyc(1);
      chk_m(mode, NRM);
      ram_rd_parity = 1'b0;
      cyc(1);
      ram_rd_valid = 1'b0;
      cyc(1);
      chk_m(mode, DIA);
      chk_w(serial_out, mode_ctrl_pkg::ERR_RAM_PARITY);
      i_mcu_model.send(mode_ctrl_pkg::CMD_ENTER_COMMAND, 1'b0, ack);
      chk_b(ack, 1'b1);
      chk_m(mode, WAI);
   endtask
   task automatic t_startup_faults();
      @(negedge clk);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      wait_mode(DIA, 90);
      chk_m(mode, DIA);
      chk_w(serial_out, mode_ctrl_pkg::ERR_WATCHDOG);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      copy_error = 1'b1;
      copy_done = 1'b1;
      wait_mode(DIA, 8);
      chk_m(mode, DIA);
      chk_w(serial_out, mode_ctrl_pkg::ERR_NVM);
   endtask

   task automatic final_report();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      {rst, copy_done, copy_error, ram_rd_valid, ram_rd_parity, cmd_done} = 6'h20;
      {cycle_end, temp_valid, chk_temp_en, sensor_fail, hard_fail} = 5'h00;
      {chk_sensor_en, ow_ok} = 2'h0;
      {ram_rd_data, cond_result, temp_raw, adc_res} = 50'h0;
      boot(12);
      t_normal();
      t_entry();
      t_commands();
      boot(2);
      t_counted();
      boot(2);
      t_parity();
      t_startup_faults();
      final_report();
   end
   initial begin
      #(5000 * 100);
      miscompares++;
      final_report();
   end
endmodule
